// file: rtl/rlc_level_control.sv
// Record level control: sample FIFO, gain reduction engine and registers
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module rlc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign inReady  = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_reg];

  // Storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_reg] <= inData;
  end

  // Pointers and count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      if (pop)
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule : rlc_fifo

// Overview of operation
// - The sample-rate field (00 96 kHz, 01 48 kHz, 10 32 kHz) must match the ADC rate and sets all timer lengths.
// - In limited recovery the recovery counter stops at 3, 7, 15 or 31 chosen by the counter-limit field.
// - The mode field picks no recovery, normal recovery or limited recovery.
// - With limit detect at 0, gain is reduced as soon as either channel exceeds the attack limit.
// - With limit detect at 1, gain is reduced only when both channels exceed the limit together.
// - Level control runs only while bit 0 of the configuration register is 1.
// - The configuration register holds rate, counter limit, mode, limit detect and enable in bits 7 to 0.
// - Recovery thresholds are -2/-3/-4/-6 dB and attack thresholds 0/-1/-2/-4 dB.
// - The second register holds recovery threshold, attack threshold, recovery time and attack time.
// - The third register is one eight-bit restart function.
// - Any write to the third register restarts level control and a read returns the gain reduction.
module rlc_level_control #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Internal side of the control port
  input  wire logic [6:0]           regAddr,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  input  wire logic [7:0]           regWdata,
  output logic [7:0]                regRdata,
  // ADC sample stream in
  input  wire logic                 sampleInValid,
  output logic                      sampleInReady,
  input  wire rlc_pkg::rlc_sample_s sampleIn,
  // Level-controlled stream out
  output logic                      sampleOutValid,
  input  wire logic                 sampleOutReady,
  output rlc_pkg::rlc_sample_s      sampleOut
);
  logic [7:0]           config_reg;
  logic [7:0]           thrTime_reg;
  logic [7:0]           gainRed_reg;
  logic [15:0]          atkTimer_reg;
  logic [15:0]          recTimer_reg;
  logic [4:0]           recCount_reg;
  logic                 restart;
  logic                 enable;
  logic                 fifoValid;
  logic                 take;
  rlc_pkg::rlc_sample_s fifoData;
  logic [7:0]           rateKhz;
  logic [15:0]          atkLen;
  logic [15:0]          recLen;
  logic [4:0]           countLimit;
  logic [15:0]          atkLevel;
  logic [15:0]          recLevel;
  logic [15:0]          magL;
  logic [15:0]          magR;
  logic                 overL;
  logic                 overR;
  logic                 attack;
  logic                 quiet;
  logic [1:0]           mode;
  logic [8:0]           gainFactor;

  // ----------------------------------------------------------------
  // Buffer
  // ----------------------------------------------------------------
  rlc_fifo #(.WIDTH($bits(rlc_pkg::rlc_sample_s)), .DEPTH(FIFO_DEPTH)) rlc_fifo_i (
    .clk      (clk),
    .nrst     (nrst),
    .inValid  (sampleInValid),
    .inReady  (sampleInReady),
    .inData   (sampleIn),
    .outValid (fifoValid),
    .outReady (take),
    .outData  (fifoData)
  );

  // Output stage stalls the FIFO when downstream holds off
  assign take = fifoValid && (!sampleOutValid || sampleOutReady);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  assign enable  = config_reg[rlc_pkg::CFG_ENABLE_BIT];
  assign restart = regWrite && (regAddr == rlc_pkg::ADDR_RESTART);
  assign mode    = config_reg[rlc_pkg::CFG_MODE_LSB +: 2];

  // Writable configuration, reserved bit 7 of the second register dropped
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      config_reg  <= rlc_pkg::CONFIG_RESET;
      thrTime_reg <= rlc_pkg::THRTIME_RESET;
    end
    else if (regWrite)
    begin
      if (regAddr == rlc_pkg::ADDR_CONFIG)
        config_reg <= regWdata;
      else if (regAddr == rlc_pkg::ADDR_THRTIME)
        thrTime_reg <= regWdata & rlc_pkg::THRTIME_MASK;
    end
  end

  // Registered read data, unmapped addresses read zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      regRdata <= 8'h00;
    else if (regRead)
    begin
      if (regAddr == rlc_pkg::ADDR_CONFIG)
        regRdata <= config_reg;
      else if (regAddr == rlc_pkg::ADDR_THRTIME)
        regRdata <= thrTime_reg;
      else if (regAddr == rlc_pkg::ADDR_RESTART)
        regRdata <= gainRed_reg;
      else
        regRdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------
  // Timer lengths in samples; reserved rate code falls back to 48 kHz
  always_comb
  begin
    case (config_reg[rlc_pkg::CFG_RATE_LSB +: 2])
      rlc_pkg::RATE_96K: rateKhz = rlc_pkg::KHZ_96;
      rlc_pkg::RATE_32K: rateKhz = rlc_pkg::KHZ_32;
      default:           rateKhz = rlc_pkg::KHZ_48;
    endcase
    atkLen = 16'(rateKhz) * 16'(thrTime_reg[rlc_pkg::THR_ATIME_BIT] ?
             rlc_pkg::ATK_MS_1 : rlc_pkg::ATK_MS_0);
    case (thrTime_reg[rlc_pkg::THR_RTIME_LSB +: 2])
      2'h0:    recLen = 16'(rateKhz) * 16'(rlc_pkg::REC_MS_0);
      2'h1:    recLen = 16'(rateKhz) * 16'(rlc_pkg::REC_MS_1);
      2'h2:    recLen = 16'(rateKhz) * 16'(rlc_pkg::REC_MS_2);
      default: recLen = 16'(rateKhz) * 16'(rlc_pkg::REC_MS_3);
    endcase
    case (config_reg[rlc_pkg::CFG_LIMIT_LSB +: 2])
      2'h0:    countLimit = rlc_pkg::LIMIT_CODE0;
      2'h1:    countLimit = rlc_pkg::LIMIT_CODE1;
      2'h2:    countLimit = rlc_pkg::LIMIT_CODE2;
      default: countLimit = rlc_pkg::LIMIT_CODE3;
    endcase
    case (thrTime_reg[rlc_pkg::THR_ATK_LSB +: 2])
      2'h0:    atkLevel = rlc_pkg::LVL_0DB;
      2'h1:    atkLevel = rlc_pkg::LVL_M1DB;
      2'h2:    atkLevel = rlc_pkg::LVL_M2DB;
      default: atkLevel = rlc_pkg::LVL_M4DB;
    endcase
    case (thrTime_reg[rlc_pkg::THR_REC_LSB +: 2])
      2'h0:    recLevel = rlc_pkg::LVL_M2DB;
      2'h1:    recLevel = rlc_pkg::LVL_M3DB;
      2'h2:    recLevel = rlc_pkg::LVL_M4DB;
      default: recLevel = rlc_pkg::LVL_M6DB;
    endcase
  end

  // ----------------------------------------------------------------
  // Level detection
  // ----------------------------------------------------------------
  // Magnitudes saturate so that full negative scale still compares
  assign magL   = fifoData.left[15] ? ((fifoData.left == 16'sh8000) ? 16'h7FFF : 16'(-fifoData.left))
                                    : 16'(fifoData.left);
  assign magR   = fifoData.right[15] ? ((fifoData.right == 16'sh8000) ? 16'h7FFF : 16'(-fifoData.right))
                                     : 16'(fifoData.right);
  assign overL  = (magL >= atkLevel);
  assign overR  = (magR >= atkLevel);
  assign attack = config_reg[rlc_pkg::CFG_BOTH_BIT] ? (overL && overR)
                                                     : (overL || overR);
  assign quiet  = (magL < recLevel) && (magR < recLevel);

  // ----------------------------------------------------------------
  // Gain engine, advanced once per sample taken from the FIFO
  // ----------------------------------------------------------------
  // Attack steps at once then waits the attack time before the next step
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gainRed_reg  <= 8'h00;
      atkTimer_reg <= 16'h0000;
      recTimer_reg <= 16'h0000;
      recCount_reg <= 5'h00;
    end
    else if (!enable || restart)
    begin
      gainRed_reg  <= 8'h00;
      atkTimer_reg <= 16'h0000;
      recTimer_reg <= 16'h0000;
      recCount_reg <= 5'h00;
    end
    else if (take)
    begin
      if (atkTimer_reg != 16'h0000)
        atkTimer_reg <= atkTimer_reg - 1'b1;
      if (attack)
      begin
        recTimer_reg <= 16'h0000;
        recCount_reg <= 5'h00;
        if (atkTimer_reg == 16'h0000)
        begin
          atkTimer_reg <= atkLen;
          gainRed_reg  <= (gainRed_reg >= rlc_pkg::GAIN_MAX) ? rlc_pkg::GAIN_MAX
                                                             : gainRed_reg + rlc_pkg::GAIN_STEP;
        end
      end
      else if (quiet && gainRed_reg != 8'h00 && (mode == rlc_pkg::MODE_NORMAL ||
               (mode == rlc_pkg::MODE_LIMITED && recCount_reg < countLimit)))
      begin
        // Recovery waits the full recovery time before each step
        if (recTimer_reg >= recLen - 16'h0001)
        begin
          recTimer_reg <= 16'h0000;
          gainRed_reg  <= (gainRed_reg < rlc_pkg::GAIN_STEP) ? 8'h00 : gainRed_reg - rlc_pkg::GAIN_STEP;
          if (mode == rlc_pkg::MODE_LIMITED)
            recCount_reg <= recCount_reg + 1'b1;
        end
        else
          recTimer_reg <= recTimer_reg + 1'b1;
      end
      else
        recTimer_reg <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Linear gain of (256 - reduction)/256, applied with the current reduction
  assign gainFactor = 9'h100 - {1'b0, gainRed_reg};

  // Registered output sample
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sampleOutValid <= 1'b0;
      sampleOut      <= '0;
    end
    else if (take)
    begin
      sampleOutValid  <= 1'b1;
      sampleOut.left  <= 16'((25'(fifoData.left) * $signed({16'h0000, gainFactor})) >>> 8);
      sampleOut.right <= 16'((25'(fifoData.right) * $signed({16'h0000, gainFactor})) >>> 8);
    end
    else if (sampleOutReady)
      sampleOutValid <= 1'b0;
  end
endmodule : rlc_level_control

// file: common/rlc_pkg.sv
// Shared constants and types for the record level control block
package rlc_pkg;
  // ----------------------------------------------------------------
  // Register addresses on the control port
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_CONFIG  = 7'h7B;
  localparam logic [6:0] ADDR_THRTIME = 7'h7C;
  localparam logic [6:0] ADDR_RESTART = 7'h7D;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_RATE_LSB   = 6;
  localparam int CFG_LIMIT_LSB  = 4;
  localparam int CFG_MODE_LSB   = 2;
  localparam int CFG_BOTH_BIT   = 1;
  localparam int CFG_ENABLE_BIT = 0;
  localparam int THR_REC_LSB    = 5;
  localparam int THR_ATK_LSB    = 3;
  localparam int THR_RTIME_LSB  = 1;
  localparam int THR_ATIME_BIT  = 0;
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [7:0] THRTIME_RESET = 8'h00;
  localparam logic [7:0] THRTIME_MASK  = 8'h7F;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_96K = 2'h0;
  localparam logic [1:0] RATE_48K = 2'h1;
  localparam logic [1:0] RATE_32K = 2'h2;
  localparam logic [7:0] KHZ_96   = 8'h60;
  localparam logic [7:0] KHZ_48   = 8'h30;
  localparam logic [7:0] KHZ_32   = 8'h20;
  localparam logic [1:0] MODE_NONE    = 2'h0;
  localparam logic [1:0] MODE_NORMAL  = 2'h1;
  localparam logic [1:0] MODE_LIMITED = 2'h2;
  localparam logic [4:0] LIMIT_CODE0 = 5'h03;
  localparam logic [4:0] LIMIT_CODE1 = 5'h07;
  localparam logic [4:0] LIMIT_CODE2 = 5'h0F;
  localparam logic [4:0] LIMIT_CODE3 = 5'h1F;

  // ----------------------------------------------------------------
  // Thresholds as linear full-scale magnitudes (0, -1, -2, -3, -4, -6 dB)
  // ----------------------------------------------------------------
  localparam logic [15:0] LVL_0DB = 16'h7FFF;
  localparam logic [15:0] LVL_M1DB = 16'h7214;
  localparam logic [15:0] LVL_M2DB = 16'h65AC;
  localparam logic [15:0] LVL_M3DB = 16'h5A9D;
  localparam logic [15:0] LVL_M4DB = 16'h50C3;
  localparam logic [15:0] LVL_M6DB = 16'h4026;

  // ----------------------------------------------------------------
  // Times in ms, then gain step and ceiling; timers count samples, so cycles = ms * kHz
  // ----------------------------------------------------------------
  localparam logic [7:0] ATK_MS_0 = 8'h01;
  localparam logic [7:0] ATK_MS_1 = 8'h04;
  localparam logic [7:0] REC_MS_0 = 8'h20;
  localparam logic [7:0] REC_MS_1 = 8'h40;
  localparam logic [7:0] REC_MS_2 = 8'h80;
  localparam logic [8:0] REC_MS_3 = 9'h100;
  localparam logic [7:0] GAIN_STEP = 8'h02;
  localparam logic [7:0] GAIN_MAX  = 8'hFE;

  // Stereo sample pair
  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } rlc_sample_s;
endpackage : rlc_pkg

// file: tb/rlc_level_control_chk.sv
// Port checker for the record level control block
`timescale 1ns/1ps
module rlc_level_control_chk #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 nrst,
  // Register port
  input wire logic [6:0]           regAddr,
  input wire logic                 regWrite,
  input wire logic                 regRead,
  input wire logic [7:0]           regWdata,
  input wire logic [7:0]           regRdata,
  // Streams
  input wire logic                 sampleInValid,
  input wire logic                 sampleInReady,
  input wire rlc_pkg::rlc_sample_s sampleIn,
  input wire logic                 sampleOutValid,
  input wire logic                 sampleOutReady,
  input wire rlc_pkg::rlc_sample_s sampleOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic       en;
  logic       enDly;
  logic [3:0] inFlight;
  // Enable shadow, delayed so a fresh disable has time to clear the gain
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en <= 1'b0;
      enDly <= 1'b0;
    end
    else
    begin
      if (regWrite && regAddr == rlc_pkg::ADDR_CONFIG) en <= regWdata[0];
      enDly <= en;
    end
  end
  // Samples taken but not yet handed on; includes the output register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) inFlight <= 4'h0;
    else inFlight <= inFlight + 4'(sampleInValid && sampleInReady) - 4'(sampleOutValid && sampleOutReady);
  end
  property p_rdata_hold; !regRead |=> $stable(regRdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_cfg_back;
    regWrite && !regRead && regAddr == rlc_pkg::ADDR_CONFIG ##1 !regWrite
    ##1 regRead && !regWrite && regAddr == rlc_pkg::ADDR_CONFIG
    |=> regRdata == $past(regWdata, 3);
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
  property p_thr_mask;
    regWrite && !regRead && regAddr == rlc_pkg::ADDR_THRTIME ##1 !regWrite
    ##1 regRead && !regWrite && regAddr == rlc_pkg::ADDR_THRTIME
    |=> regRdata == ($past(regWdata, 3) & 8'h7F);
  endproperty
  a_thr_mask: assert property (p_thr_mask) else $error("threshold readback wrong");
  property p_unmapped; regRead && !(regAddr inside {7'h7B, 7'h7C, 7'h7D}) |=> regRdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_restart;
    regWrite && !regRead && regAddr == rlc_pkg::ADDR_RESTART ##1 !regWrite && inFlight == 4'h0
    ##1 regRead && !regWrite && regAddr == rlc_pkg::ADDR_RESTART
    |=> regRdata == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("gain not cleared by restart");
  property p_off_gain; regRead && regAddr == rlc_pkg::ADDR_RESTART && !en && !enDly |=> regRdata == 8'h00; endproperty
  a_off_gain: assert property (p_off_gain) else $error("gain reduction while disabled");
  property p_passthru;
    sampleInValid && sampleInReady && inFlight == 4'h0 && !en && !enDly
    |-> ##2 sampleOutValid && sampleOut == $past(sampleIn, 2);
  endproperty
  a_passthru: assert property (p_passthru) else $error("disabled path altered a sample");
  property p_out_hold; sampleOutValid && !sampleOutReady |=> sampleOutValid && $stable(sampleOut); endproperty
  a_out_hold: assert property (p_out_hold) else $error("output changed while stalled");
  property p_room; inFlight < FIFO_DEPTH |-> sampleInReady; endproperty
  a_room: assert property (p_room) else $error("input refused with room left");
  c_enable: cover property (regWrite && regAddr == rlc_pkg::ADDR_CONFIG && regWdata[0]);
  c_full: cover property (!sampleInReady);
  c_restart: cover property (regWrite && regAddr == rlc_pkg::ADDR_RESTART);
endmodule : rlc_level_control_chk

// file: tb/rlc_host_model.sv
// Host model driving the control port of the level control block
`timescale 1ns/1ps
module rlc_host_model (
  // Clock
  input wire logic        clk,
  // Control port
  output logic [6:0]      regAddr,
  output logic            regWrite,
  output logic            regRead,
  output logic [7:0]      regWdata,
  input wire logic [7:0]  regRdata
);
  // Idle port at time zero
  initial
  begin
    regAddr = 7'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'h00;
  end
  // One-cycle strobe; released fields inverted so stale values never pass for good ones
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regWdata <= ~d;
    regAddr <= ~a;
    @(posedge clk);
  endtask : wr
  // Read data is taken one edge after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge clk);
    d = regRdata;
  endtask : rd
endmodule : rlc_host_model

// file: tb/rlc_level_control_tb_top.sv
// Self-checking bench for the record level control block
`timescale 1ns/1ps
module rlc_level_control_tb_top;
  // ----------------------------------------------------------------
  // Wiring
  // ----------------------------------------------------------------
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic [6:0]           regAddr;
  logic                 regWrite;
  logic                 regRead;
  logic [7:0]           regWdata;
  logic [7:0]           regRdata;
  logic [7:0]           rdv;
  logic                 sampleInValid = 1'b0;
  logic                 sampleInReady;
  logic                 sampleOutValid;
  logic                 sampleOutReady = 1'b1;
  rlc_pkg::rlc_sample_s sampleIn = '0;
  rlc_pkg::rlc_sample_s sampleOut;
  rlc_pkg::rlc_sample_s lastOut;
  int                   inCnt = 0;
  int                   outCnt = 0;
  int                   inBase;
  int                   err_count = 0;
  int                   total_checks = 0;
  always #2 clk = ~clk;
  rlc_level_control #(.FIFO_DEPTH(8)) rlc_level_control_i (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .sampleInValid(sampleInValid), .sampleInReady(sampleInReady), .sampleIn(sampleIn),
    .sampleOutValid(sampleOutValid), .sampleOutReady(sampleOutReady), .sampleOut(sampleOut));
  rlc_host_model rlc_host_model_i (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata));
  // Count handshakes at the sampling edge
  always @(posedge clk)
  begin
    if (sampleInValid && sampleInReady) inCnt <= inCnt + 1;
    if (sampleOutValid && sampleOutReady) outCnt <= outCnt + 1;
    if (sampleOutValid && sampleOutReady) lastOut <= sampleOut;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Bounded wait until every sample taken has left
  task automatic drain;
    @(posedge clk);
    for (int i = 0; i < 60 && inCnt != outCnt; i++) @(posedge clk);
    #1;
  endtask : drain
  task automatic pushN(input logic [31:0] s, input int n);
    sampleInValid <= 1'b1;
    sampleIn <= s;
    repeat (n) @(posedge clk iff sampleInReady);
    sampleInValid <= 1'b0;
    drain();
  endtask : pushN
  task automatic rdChk(input logic [6:0] a, input logic [7:0] exp);
    rlc_host_model_i.rd(a, rdv);
    chk("register", {17'h0, a, exp}, {17'h0, a, rdv});
  endtask : rdChk
  task automatic final_report;
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // Watchdog well beyond the roughly 6300 cycles the sequence needs
  initial
  begin
    #160000;
    err_count++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    chk("reset outputs", 32'h2, {regRdata, 22'h0, sampleInReady, sampleOutValid});
    nrst <= 1'b1;
    @(posedge clk);
    rlc_host_model_i.wr(rlc_pkg::ADDR_CONFIG, 8'hB6);
    rdChk(rlc_pkg::ADDR_CONFIG, 8'hB6);
    rlc_host_model_i.wr(rlc_pkg::ADDR_THRTIME, 8'hFF);
    rdChk(rlc_pkg::ADDR_THRTIME, 8'h7F);
    rdChk(7'h10, 8'h00);
    pushN(32'h6000_6000, 1);
    chk("disabled sample", 32'h6000_6000, lastOut);
    rdChk(rlc_pkg::ADDR_RESTART, 8'h00);
    // Attack at -4 dB, either then both channels; the negative right side tests magnitude
    rlc_host_model_i.wr(rlc_pkg::ADDR_THRTIME, 8'h18);
    for (int b = 0; b < 2; b++)
    begin
      rlc_host_model_i.wr(rlc_pkg::ADDR_CONFIG, {rlc_pkg::RATE_32K, 4'h0, b[0], 1'b1});
      rlc_host_model_i.wr(rlc_pkg::ADDR_RESTART, 8'h00);
      pushN(32'h50C2_AF3E, 1);
      rdChk(rlc_pkg::ADDR_RESTART, 8'h00);
      pushN(32'h50C3_0000, 1);
      rdChk(rlc_pkg::ADDR_RESTART, b ? 8'h00 : 8'h02);
      pushN(32'h50C3_AF3D, 1);
      rdChk(rlc_pkg::ADDR_RESTART, 8'h02);
    end
    pushN(32'h1000_F000, 1);
    chk("scaled sample", 32'h0FE0_F020, lastOut);
    rlc_host_model_i.wr(rlc_pkg::ADDR_RESTART, 8'hA5);
    rdChk(rlc_pkg::ADDR_RESTART, 8'h00);
    // Attack spacing follows the rate: 40 loud samples step twice at 32 kHz, once at 96 kHz
    for (int r = 0; r < 2; r++)
    begin
      rlc_host_model_i.wr(rlc_pkg::ADDR_CONFIG, {r ? rlc_pkg::RATE_96K : rlc_pkg::RATE_32K, 6'h01});
      rlc_host_model_i.wr(rlc_pkg::ADDR_RESTART, 8'h00);
      pushN(32'h6000_6000, 40);
      rdChk(rlc_pkg::ADDR_RESTART, r ? 8'h02 : 8'h04);
    end
    pushN(32'h6000_6000, 1);
    rlc_host_model_i.wr(rlc_pkg::ADDR_CONFIG, 8'h80);
    rdChk(rlc_pkg::ADDR_RESTART, 8'h00);
    // Recovery modes; last pass runs at 48 kHz where 1100 quiet samples fall short
    for (int m = 0; m < 5; m++)
    begin
      rlc_host_model_i.wr(rlc_pkg::ADDR_CONFIG, {(m == 4) ? 2'h1 : 2'h2, 2'h0, (m == 4) ? 2'h1 : 2'(m), 2'h1});
      rlc_host_model_i.wr(rlc_pkg::ADDR_RESTART, 8'hFF);
      pushN(32'h6000_6000, 1);
      pushN(32'h0100_0100, 1100);
      rdChk(rlc_pkg::ADDR_RESTART, (m == 1 || m == 2) ? 8'h00 : 8'h02);
    end
    pushN(32'h0100_0100, 500);
    rdChk(rlc_pkg::ADDR_RESTART, 8'h00);
    // Stall the sink: eight in the buffer plus one in the output register
    rlc_host_model_i.wr(rlc_pkg::ADDR_CONFIG, 8'h00);
    inBase = inCnt;
    sampleOutReady <= 1'b0;
    sampleInValid <= 1'b1;
    sampleIn <= 32'h0007_0007;
    repeat (20) @(posedge clk);
    sampleInValid <= 1'b0;
    @(posedge clk);
    #1;
    chk("stalled fill", {31'd9, 1'b0}, {31'(inCnt - inBase), sampleInReady});
    sampleOutReady <= 1'b1;
    drain();
    chk("drained", {31'd9, 1'b0}, {31'(outCnt - inBase), sampleOutValid});
    final_report();
  end
endmodule : rlc_level_control_tb_top

bind rlc_level_control rlc_level_control_chk #(.FIFO_DEPTH(FIFO_DEPTH)) rlc_level_control_chk_i (.clk(clk),
  .nrst(nrst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
  .regRdata(regRdata), .sampleInValid(sampleInValid), .sampleInReady(sampleInReady), .sampleIn(sampleIn),
  .sampleOutValid(sampleOutValid), .sampleOutReady(sampleOutReady), .sampleOut(sampleOut));
